// [nadt_pkg.sv]
package nadt_pkg;
  localparam int NADT_AW = 42;
  // Destination patterns
  localparam int HOST_BIT = 41;
  localparam int HOST_SEL_BIT = 40;
  localparam int HOST_LA_W = 40;
  localparam logic [1:0] DDR_PAT = 2'h1;
  localparam int DDR_PAT_LSB = 40;
  localparam int DDR_LA_W = 40;
  localparam logic [4:0] GDDR_PAT = 5'h00;
  localparam int GDDR_PAT_LSB = 37;
  localparam int GDDR_SEL_LSB = 33;
  localparam int GDDR_SEL_W = 4;
  localparam int GDDR_LA_W = 33;
  localparam logic [6:0] NODE_PAT = 7'h08;
  localparam int NODE_PAT_LSB = 35;
  localparam int NODE_COL_LSB = 31;
  localparam int NODE_COL_W = 4;
  localparam int NODE_ROW_LSB = 28;
  localparam int NODE_ROW_W = 3;
  localparam int NODE_LA_W = 28;
  localparam logic [3:0] NODE_COL_MIN = 4'h1;
  localparam logic [3:0] NODE_COL_MAX = 4'hA;
  localparam logic [7:0] CSR_PAT = 8'h20;
  localparam int CSR_PAT_LSB = 34;
  localparam int CSR_AW = 34;
  localparam int CSR_TGT_LSB = 28;
  localparam int CSR_TGT_W = 6;
  localparam int CSR_SUB_LSB = 24;
  localparam int CSR_SUB_W = 4;
  localparam int CSR_BYTE_W = 24;
  localparam logic [11:0] CFG_PAT = 12'h300;
  localparam int CFG_PAT_LSB = 30;
  localparam int CFG_LA_W = 30;
  // Translatable fields
  localparam int DDR_PG_LSB = 26;
  localparam int DDR_PG_W = 7;
  localparam int GDDR_PG_LSB = 26;
  localparam int GDDR_PG_W = 3;
  // Register target codes
  localparam logic [5:0] TGT_GDDR0 = 6'h00;
  localparam logic [5:0] TGT_GDDR3 = 6'h03;
  localparam logic [5:0] TGT_DDR = 6'h09;
  localparam logic [5:0] TGT_GPIO_S = 6'h0B;
  localparam logic [5:0] TGT_TEMP = 6'h0C;
  localparam logic [5:0] TGT_GDDR4 = 6'h10;
  localparam logic [5:0] TGT_GDDR7 = 6'h13;
  localparam logic [5:0] TGT_PCIE16 = 6'h19;
  localparam logic [5:0] TGT_PCIE8 = 6'h1A;
  localparam logic [5:0] TGT_ETH0 = 6'h1B;
  localparam logic [5:0] TGT_ETH1 = 6'h1C;
  localparam logic [5:0] TGT_GPIO_N = 6'h1D;
  // Translation table and prohibition mask selects for loading
  localparam logic [2:0] TBL_DDR_PG = 3'h0;
  localparam logic [2:0] TBL_GDDR_SEL = 3'h1;
  localparam logic [2:0] TBL_GDDR_PG = 3'h2;
  localparam logic [2:0] TBL_NODE_COL = 3'h3;
  localparam logic [2:0] TBL_NODE_ROW = 3'h4;
  localparam logic [2:0] TBL_BLOCK = 3'h5;
  localparam int TBL_IDX_W = 7;
  localparam int TBL_DAT_W = 7;
  // Prohibition mask bit positions
  localparam int BLK_GDDR = 0;
  localparam int BLK_DDR = 1;
  localparam int BLK_HOST0 = 2;
  localparam int BLK_HOST1 = 3;
  localparam int BLK_CFG = 4;
  localparam int BLK_CSR = 5;
  localparam int BLK_NODE = 6;
  localparam int BLK_W = 7;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [6:0] {
    DST_HOST = 7'h01,
    DST_DDR = 7'h02,
    DST_GDDR = 7'h04,
    DST_NODE = 7'h08,
    DST_CSR = 7'h10,
    DST_CFG = 7'h20,
    DST_ERR = 7'h40
  } nadt_dest_e;

  typedef struct packed {
    logic write;
    logic [NADT_AW-1:0] addr;
  } nadt_req_s;

  typedef struct packed {
    logic write;
    nadt_dest_e dest;
    logic [5:0] unit;
    logic [3:0] sub;
    logic [39:0] local_addr;
    logic [NADT_AW-1:0] addr;
    logic [1:0] resp;
  } nadt_route_s;

  typedef struct packed {
    logic wr;
    logic [2:0] tbl;
    logic [TBL_IDX_W-1:0] idx;
    logic [TBL_DAT_W-1:0] data;
  } nadt_cfg_s;
endpackage

// [nadt_router.sv]
`timescale 1ns/100ps
module nadt_router
  import nadt_pkg::*;
#(
  parameter int DDR_PG_N = 128,
  parameter int GDDR_SEL_N = 16,
  parameter int GDDR_PG_N = 8,
  parameter int NODE_COL_N = 16,
  parameter int NODE_ROW_N = 8
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire nadt_cfg_s cfg,
  input wire logic cfg_done,
  output logic cfg_locked,
  input wire logic req_valid,
  output logic req_ready,
  input wire nadt_req_s req,
  output logic route_valid,
  input wire logic route_ready,
  output nadt_route_s route
);

  typedef struct packed {
    logic locked;
    logic [BLK_W-1:0] block;
    logic [DDR_PG_N-1:0][DDR_PG_W-1:0] ddr_pg;
    logic [GDDR_SEL_N-1:0][GDDR_SEL_W-1:0] gddr_sel;
    logic [GDDR_PG_N-1:0][GDDR_PG_W-1:0] gddr_pg;
    logic [NODE_COL_N-1:0][NODE_COL_W-1:0] node_col;
    logic [NODE_ROW_N-1:0][NODE_ROW_W-1:0] node_row;
    logic out_valid;
    nadt_route_s out;
  } nadt_state_s;

  nadt_state_s st_q;
  nadt_state_s st_d;

  // Swap the translatable fields of one address through the tables
  function automatic logic [NADT_AW-1:0] translate(input nadt_state_s s,
                                                    input logic [NADT_AW-1:0] a);
    logic [NADT_AW-1:0] t;
    t = a;
    if (a[NADT_AW-1 -: 2] == DDR_PAT)
    begin
      t[DDR_PG_LSB +: DDR_PG_W] = s.ddr_pg[a[DDR_PG_LSB +: DDR_PG_W]];
    end
    else if (a[NADT_AW-1 -: 5] == GDDR_PAT)
    begin
      t[GDDR_SEL_LSB +: GDDR_SEL_W] = s.gddr_sel[a[GDDR_SEL_LSB +: GDDR_SEL_W]];
      t[GDDR_PG_LSB +: GDDR_PG_W] = s.gddr_pg[a[GDDR_PG_LSB +: GDDR_PG_W]];
    end
    else if (a[NADT_AW-1 -: 7] == NODE_PAT)
    begin
      t[NODE_COL_LSB +: NODE_COL_W] = s.node_col[a[NODE_COL_LSB +: NODE_COL_W]];
      t[NODE_ROW_LSB +: NODE_ROW_W] = s.node_row[a[NODE_ROW_LSB +: NODE_ROW_W]];
    end
    return t;
  endfunction

  function automatic logic csr_target_ok(input logic [CSR_TGT_W-1:0] c);
    logic ok;
    ok = (c >= TGT_GDDR0 && c <= TGT_GDDR3) || c == TGT_DDR || c == TGT_GPIO_S ||
         c == TGT_TEMP;
    ok = ok || (c >= TGT_GDDR4 && c <= TGT_GDDR7) || c == TGT_PCIE16 ||
         c == TGT_PCIE8 || c == TGT_ETH0 || c == TGT_ETH1 || c == TGT_GPIO_N;
    return ok;
  endfunction

  // Decode a translated address into a routed request
  function automatic nadt_route_s decode(input logic [BLK_W-1:0] blk,
                                         input nadt_req_s r);
    nadt_route_s o;
    logic [NADT_AW-1:0] a;
    logic [NODE_COL_W-1:0] col;
    a = r.addr;
    col = a[NODE_COL_LSB +: NODE_COL_W];
    o = '0;
    o.write = r.write;
    o.addr = a;
    o.dest = DST_ERR;
    o.resp = RESP_DECERR;
    // Only the top bits pick the class
    if (a[HOST_BIT])
    begin
      o.dest = DST_HOST;
      o.unit = {5'h00, a[HOST_SEL_BIT]};
      o.local_addr = a[HOST_LA_W-1:0];
      if (blk[a[HOST_SEL_BIT] ? BLK_HOST1 : BLK_HOST0])
      begin
        o.dest = DST_ERR;
      end
    end
    else if (a[DDR_PAT_LSB +: 2] == DDR_PAT)
    begin
      o.dest = blk[BLK_DDR] ? DST_ERR : DST_DDR;
      o.local_addr = a[DDR_LA_W-1:0];
    end
    else if (a[GDDR_PAT_LSB +: 5] == GDDR_PAT)
    begin
      o.dest = blk[BLK_GDDR] ? DST_ERR : DST_GDDR;
      o.unit = {3'h0, a[GDDR_SEL_LSB+1 +: 3]};
      o.sub = {3'h0, a[GDDR_SEL_LSB]};
      o.local_addr = {7'h00, a[GDDR_LA_W-1:0]};
    end
    else if (a[NODE_PAT_LSB +: 7] == NODE_PAT)
    begin
      // Columns outside 1..10 name no node
      if (!blk[BLK_NODE] && col >= NODE_COL_MIN && col <= NODE_COL_MAX)
      begin
        o.dest = DST_NODE;
      end
      o.unit = {2'h0, col};
      o.sub = {1'h0, a[NODE_ROW_LSB +: NODE_ROW_W]};
      o.local_addr = {12'h000, a[NODE_LA_W-1:0]};
    end
    else if (a[CSR_PAT_LSB +: 8] == CSR_PAT)
    begin
      if (!blk[BLK_CSR] && csr_target_ok(a[CSR_TGT_LSB +: CSR_TGT_W]))
      begin
        o.dest = DST_CSR;
      end
      o.unit = a[CSR_TGT_LSB +: CSR_TGT_W];
      o.sub = a[CSR_SUB_LSB +: CSR_SUB_W];
      o.local_addr = {6'h00, a[CSR_AW-1:0]};
    end
    else if (a[CFG_PAT_LSB +: 12] == CFG_PAT)
    begin
      o.dest = blk[BLK_CFG] ? DST_ERR : DST_CFG;
      o.local_addr = {10'h000, a[CFG_LA_W-1:0]};
    end
    if (o.dest != DST_ERR)
    begin
      o.resp = RESP_OKAY;
    end
    else
    begin
      o.local_addr = '0;
      o.unit = '0;
      o.sub = '0;
    end
    return o;
  endfunction

  logic accept;
  nadt_req_s xreq;

  assign req_ready = ce && !rst && (!st_q.out_valid || route_ready);
  assign accept = req_valid && req_ready;
  assign route_valid = st_q.out_valid;
  assign route = st_q.out;
  assign cfg_locked = st_q.locked;

  always_comb
  begin
    xreq.write = req.write;
    xreq.addr = translate(st_q, req.addr);
    st_d = st_q;
    if (rst)
    begin
      st_d = '0;
      // Identity mapping until configured
      for (int i = 0; i < DDR_PG_N; i++)
      begin
        st_d.ddr_pg[i] = DDR_PG_W'(i);
      end
      for (int i = 0; i < GDDR_SEL_N; i++)
      begin
        st_d.gddr_sel[i] = GDDR_SEL_W'(i);
      end
      for (int i = 0; i < GDDR_PG_N; i++)
      begin
        st_d.gddr_pg[i] = GDDR_PG_W'(i);
      end
      for (int i = 0; i < NODE_COL_N; i++)
      begin
        st_d.node_col[i] = NODE_COL_W'(i);
      end
      for (int i = 0; i < NODE_ROW_N; i++)
      begin
        st_d.node_row[i] = NODE_ROW_W'(i);
      end
      st_d.out.dest = DST_ERR;
      st_d.out.resp = RESP_DECERR;
    end
    else if (ce)
    begin
      // Table writes only before the lock
      if (cfg.wr && !st_q.locked)
      begin
        case (cfg.tbl)
          TBL_DDR_PG: st_d.ddr_pg[cfg.idx] = cfg.data[DDR_PG_W-1:0];
          TBL_GDDR_SEL: st_d.gddr_sel[cfg.idx[GDDR_SEL_W-1:0]] = cfg.data[GDDR_SEL_W-1:0];
          TBL_GDDR_PG: st_d.gddr_pg[cfg.idx[GDDR_PG_W-1:0]] = cfg.data[GDDR_PG_W-1:0];
          TBL_NODE_COL: st_d.node_col[cfg.idx[NODE_COL_W-1:0]] = cfg.data[NODE_COL_W-1:0];
          TBL_NODE_ROW: st_d.node_row[cfg.idx[NODE_ROW_W-1:0]] = cfg.data[NODE_ROW_W-1:0];
          TBL_BLOCK: st_d.block = cfg.data[BLK_W-1:0];
          default: st_d.block = st_q.block;
        endcase
      end
      if (cfg_done)
      begin
        st_d.locked = 1'h1;
      end
      if (route_ready && st_q.out_valid)
      begin
        st_d.out_valid = 1'h0;
      end
      if (accept)
      begin
        st_d.out_valid = 1'h1;
        st_d.out = decode(st_q.block, xreq);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    st_q <= st_d;
  end

endmodule

// [nadt_router_chk.sv]
`timescale 1ns/100ps
module nadt_router_chk
  import nadt_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire nadt_cfg_s cfg,
  input wire logic cfg_done,
  input wire logic cfg_locked,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire nadt_req_s req,
  input wire logic route_valid,
  input wire logic route_ready,
  input wire nadt_route_s route
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic take = req_valid && req_ready;
  property p_answer; take |=> route_valid && route.write == $past(req.write); endproperty
  a_answer: assert property (p_answer) else $error("no route after accept");
  property p_hold; route_valid && !route_ready |=> route_valid && $stable(route); endproperty
  a_hold: assert property (p_hold) else $error("route changed while stalled");
  property p_keep; take |=> route.addr[25:0] == $past(req.addr[25:0]); endproperty
  a_keep: assert property (p_keep) else $error("low bits altered");
  property p_host;
    take && req.addr[41] |=> route.addr == $past(req.addr) && route.dest inside {DST_HOST, DST_ERR};
  endproperty
  a_host: assert property (p_host) else $error("host route wrong");
  property p_ddr;
    route_valid && route.dest == DST_DDR |-> route.addr[41:40] == DDR_PAT
      && route.local_addr == route.addr[39:0];
  endproperty
  a_ddr: assert property (p_ddr) else $error("ddr fields wrong");
  property p_gddr;
    route_valid && route.dest == DST_GDDR |-> route.addr[41:37] == GDDR_PAT
      && route.unit == {3'h0, route.addr[36:34]} && route.sub == {3'h0, route.addr[33]}
      && route.local_addr == {7'h00, route.addr[32:0]};
  endproperty
  a_gddr: assert property (p_gddr) else $error("gddr fields wrong");
  property p_node;
    route_valid && route.dest == DST_NODE |-> route.addr[41:35] == NODE_PAT
      && route.unit == {2'h0, route.addr[34:31]} && route.unit inside {[1:10]}
      && route.sub == {1'h0, route.addr[30:28]} && route.local_addr == {12'h000, route.addr[27:0]};
  endproperty
  a_node: assert property (p_node) else $error("node fields wrong");
  property p_csr;
    route_valid && route.dest == DST_CSR |-> route.addr[41:34] == CSR_PAT
      && route.unit == route.addr[33:28] && route.sub == route.addr[27:24]
      && route.local_addr == {6'h00, route.addr[33:0]};
  endproperty
  a_csr: assert property (p_csr) else $error("register space fields wrong");
  property p_cfgu;
    route_valid && route.dest == DST_CFG |-> route.addr[41:30] == CFG_PAT
      && route.local_addr == {10'h000, route.addr[29:0]};
  endproperty
  a_cfgu: assert property (p_cfgu) else $error("config unit fields wrong");
  property p_err;
    route_valid && route.dest == DST_ERR |-> route.resp == RESP_DECERR
      && route.unit == 6'h00 && route.sub == 4'h0 && route.local_addr == 40'h0000000000;
  endproperty
  a_err: assert property (p_err) else $error("error route wrong");
  property p_lock; (ce && cfg_done) || cfg_locked |=> cfg_locked; endproperty
  a_lock: assert property (p_lock) else $error("lock not held");
endmodule
bind nadt_router nadt_router_chk u_chk (.clock(clock), .rst(rst), .ce(ce), .cfg(cfg),
  .cfg_done(cfg_done), .cfg_locked(cfg_locked), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .route_valid(route_valid), .route_ready(route_ready), .route(route));

// [nadt_sink.sv]
`timescale 1ns/100ps
module nadt_sink (
  input wire logic clock,
  input wire logic slow,
  output logic route_ready
);
  logic [1:0] cnt_q = 2'h0;
  initial route_ready = 1'b1;
  // Slow mode accepts one cycle in four
  always @(posedge clock)
  begin
    #1;
    cnt_q <= cnt_q + 2'h1;
    route_ready <= !slow || cnt_q == 2'h2;
  end
endmodule

// [tb_noc_address_decode_translate.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_noc_address_decode_translate;
  import nadt_pkg::*;
  typedef struct packed {logic [41:0] a; nadt_dest_e d; logic [5:0] u; logic [3:0] s;
    logic [39:0] la;} nadt_row_s;
  logic clock = 0, rst = 1, ce = 1, cfg_done = 0, req_valid = 0, slow = 0;
  logic cfg_locked, req_ready, route_valid, route_ready;
  nadt_cfg_s cfg = '0;
  nadt_req_s req = '0;
  nadt_route_s route, r;
  int failures = 0, checked = 0;
  logic ok;
  nadt_row_s rows [8] = '{
    '{42'h3123456789A, DST_HOST, 6'h01, 4'h0, 40'h123456789A},
    '{42'h1FFFFFFFFFF, DST_DDR, 6'h00, 4'h0, 40'hFFFFFFFFFF},
    '{42'h01F23456789, DST_GDDR, 6'h07, 4'h1, 40'h0123456789},
    '{42'h0457ABCDEF0, DST_NODE, 6'h0A, 4'h7, 40'h000ABCDEF0},
    '{42'h04010000000, DST_ERR, 6'h00, 4'h0, 40'h0000000000},
    '{42'h04580000000, DST_ERR, 6'h00, 4'h0, 40'h0000000000},
    '{42'h0C03FFFFFFF, DST_CFG, 6'h00, 4'h0, 40'h003FFFFFFF},
    '{42'h02000000000, DST_ERR, 6'h00, 4'h0, 40'h0000000000}};
  nadt_router dut (.clock(clock), .rst(rst), .ce(ce), .cfg(cfg), .cfg_done(cfg_done),
    .cfg_locked(cfg_locked), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .route_valid(route_valid), .route_ready(route_ready), .route(route));
  nadt_sink sink (.clock(clock), .slow(slow), .route_ready(route_ready));
  initial forever #20 clock = !clock;
  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [41:0] a);
    int n;
    int m;
    req = '{w, a};
    req_valid = 1;
    // Request stands until an edge that sees ready high
    for (n = 0; n < 50; n++)
    begin
      @(posedge clock);
      if (req_ready) break;
    end
    #1 req_valid = 0;
    for (m = 0; m < 50 && n < 50; m++)
    begin
      @(posedge clock);
      if (route_valid && route_ready) break;
    end
    r = route;
    if (n == 50 || m == 50)
    begin
      failures++;
      print_verdict();
    end
    #1;
  endtask
  task automatic load(input logic [2:0] t, input logic [6:0] i, input logic [6:0] d);
    cfg = '{1'b1, t, i, d};
    @(posedge clock);
    #1;
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    #1 rst = 0;
    `CHK("reset_valid", 1'b0, route_valid)
    `CHK("reset_resp", RESP_DECERR, route.resp)
    `CHK("reset_lock", 1'b0, cfg_locked)
    for (int i = 0; i < 8; i++)
    begin
      slow = i[2];
      xfer(i[0], rows[i].a);
      `CHK("write", i[0], r.write)
      `CHK("dest", rows[i].d, r.dest)
      `CHK("local", rows[i].la, r.local_addr)
      `CHK("resp", rows[i].d == DST_ERR ? RESP_DECERR : RESP_OKAY, r.resp)
      if (rows[i].d != DST_DDR && rows[i].d != DST_CFG)
      begin
        `CHK("unit", rows[i].u, r.unit)
        `CHK("sub", rows[i].s, r.sub)
      end
    end
    $display("decode rows done");
    for (int c = 0; c < 64; c++)
    begin
      ok = c < 4 || c == 9 || c == 11 || c == 12 || (c > 15 && c < 20) || (c > 24 && c < 30);
      xfer(1'b1, {8'h20, c[5:0], 4'h5, 24'hABCDEF});
      `CHK("csr_dest", ok ? DST_CSR : DST_ERR, r.dest)
      if (ok)
      begin
        `CHK("csr_unit", c[5:0], r.unit)
        `CHK("csr_sub", 4'h5, r.sub)
        `CHK("csr_local", {6'h00, c[5:0], 4'h5, 24'hABCDEF}, r.local_addr)
      end
    end
    $display("register targets done");
    load(TBL_GDDR_SEL, 7'h00, 7'h05);
    load(TBL_GDDR_PG, 7'h00, 7'h03);
    load(TBL_NODE_COL, 7'h01, 7'h03);
    load(TBL_NODE_ROW, 7'h02, 7'h05);
    cfg_done = 1;
    load(TBL_BLOCK, 7'h00, 7'h02);
    cfg_done = 0;
    `CHK("locked", 1'b1, cfg_locked)
    load(TBL_BLOCK, 7'h00, 7'h00);
    cfg = '0;
    xfer(1'b0, 42'h00000000123);
    `CHK("tr_dest", DST_GDDR, r.dest)
    `CHK("tr_unit", 6'h02, r.unit)
    `CHK("tr_sub", 4'h1, r.sub)
    `CHK("tr_local", 40'h000C000123, r.local_addr)
    xfer(1'b0, 42'h040A0000123);
    `CHK("tr_col", 6'h03, r.unit)
    `CHK("tr_row", 4'h5, r.sub)
    `CHK("tr_node", 42'h041D0000123, r.addr)
    xfer(1'b0, 42'h10000000000);
    `CHK("blocked", DST_ERR, r.dest)
    xfer(1'b0, 42'h20000000000);
    `CHK("host0", DST_HOST, r.dest)
    $display("translation done");
    rst = 1;
    @(posedge clock);
    #1 rst = 0;
    `CHK("relock", 1'b0, cfg_locked)
    load(TBL_DDR_PG, 7'h00, 7'h7F);
    // Frozen by clock enable: this mask write must not land
    ce = 0;
    load(TBL_BLOCK, 7'h00, 7'h7F);
    `CHK("ce_ready", 1'h0, req_ready)
    ce = 1;
    cfg = '0;
    xfer(1'b0, 42'h10000000000);
    `CHK("unblocked", DST_DDR, r.dest)
    `CHK("ddr_page", 40'h01FC000000, r.local_addr)
    $display("second reset done");
    print_verdict();
  end
endmodule
